// ===== logic/svm_top.sv
// What this block does
// - Channel-1 level code, five legal values
// - Channel-2 level code, same legal values
// - Channels 1,2 keep state and crossing flags
// - Channel-2 crossing flag set on each crossing
// - Reset while below; release delayed or timed
// - Interrupt maskable or not, chosen edges
// - Channel 0 gives only delayed-release reset
// - Filter samples oscillator divided by 2..16
// - Filter-disable low turns filter on
// - Channels 1,2 pulse events on crossings
// - Mode bit: 0 interrupt, 1 reset
// - Channel-0 level codes 10 and 11 only
`timescale 1ns/10ps
module svm_top
(
  // Clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        SYS_RST_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Comparators and oscillator
  input  wire logic [2:0]  CMP_ABOVE_IN,
  input  wire logic        LOW_SPEED_OSC_IN,
  // Analog controls
  output logic [1:0]       LVL0_SEL_OUT,
  output logic [3:0]       LVL1_SEL_OUT,
  output logic [3:0]       LVL2_SEL_OUT,
  output logic [2:0]       DET_ENABLE_OUT,
  // Results
  output logic             MON_RESET_OUT,
  output logic             MON_IRQ_OUT,
  output logic             MON_NMI_OUT,
  output logic [1:0]       EVENT_OUT,
  output logic             INT_OUT
);

  // ----------------------------------------------------------------
  // Input synchronisers and oscillator edge
  // ----------------------------------------------------------------
  logic [3:0] sa_r;
  logic [3:0] sb_r;
  logic       osc_d_r;
  logic       osc_edge;

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      sa_r    <= 4'h7;
      sb_r    <= 4'h7;
      osc_d_r <= 1'b0;
    end
    else
    begin
      sa_r    <= {LOW_SPEED_OSC_IN, CMP_ABOVE_IN};
      sb_r    <= sa_r;
      osc_d_r <= sb_r[3];
    end
  end

  assign osc_edge = sb_r[3] & ~osc_d_r;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]             lvl_r, lvl_nxt;
  logic [7:0]             ctl_r   [1:2];
  logic [7:0]             ctl_nxt [1:2];
  logic [2:0]             den_r, den_nxt;
  logic [1:0]             lvl0_r, lvl0_nxt;
  logic [7:0]             icfg_r, icfg_nxt;
  logic [2:1]             det_r, det_nxt;
  logic [2:0]             ist_r, ist_nxt;
  logic [2:0]             imsk_r, imsk_nxt;
  logic [2:0]             prev_r, prev_nxt;
  logic [svm_pkg::CNT_W-1:0] cnt_r   [0:2];
  logic [svm_pkg::CNT_W-1:0] cnt_nxt [0:2];
  logic                   rst_r, rst_nxt;
  logic                   irq_r, irq_nxt;
  logic                   nmi_r, nmi_nxt;
  logic [1:0]             evt_r, evt_nxt;
  logic                   int_r, int_nxt;
  logic                   rdy_r, rdy_nxt;
  logic                   err_r, err_nxt;
  logic [31:0]            rd_r, rd_nxt;

  logic [2:1] filt_q;
  logic [2:1] samp;
  logic [2:0] lvl_f;
  logic [2:0] act;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] resm;
  logic [2:0] chrst;
  logic [2:1] hit;
  logic       wr;
  logic       rd;
  logic       hit_any;

  // ----------------------------------------------------------------
  // Digital filters
  // ----------------------------------------------------------------
  for (genvar g = 1; g <= 2; g++)
  begin : g_ch
    svm_div u_div
    (
      .clk_in      (MCLK_IN),
      .rst_in      (SYS_RST_IN),
      .osc_edge_in (osc_edge),
      .sel_in      (ctl_r[g][svm_pkg::CTL_FSLO +: 2]),
      .sample_out  (samp[g])
    );
    svm_filt u_filt
    (
      .clk_in    (MCLK_IN),
      .rst_in    (SYS_RST_IN),
      .sample_in (samp[g]),
      .d_in      (sb_r[g]),
      .q_out     (filt_q[g])
    );
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    wr = PSEL_IN & PENABLE_IN & PWRITE_IN & rdy_r;
    rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN & ~rdy_r;
    lvl_nxt  = lvl_r;
    ctl_nxt  = ctl_r;
    den_nxt  = den_r;
    lvl0_nxt = lvl0_r;
    icfg_nxt = icfg_r;
    det_nxt  = det_r;
    ist_nxt  = ist_r;
    imsk_nxt = imsk_r;
    // Channel 0 has no filter; 1 and 2 filter when enabled
    lvl_f[0] = sb_r[0];
    act[0]   = den_r[0];
    resm[0]  = den_r[0];
    for (int i = 1; i <= 2; i++)
    begin
      lvl_f[i] = ctl_r[i][svm_pkg::CTL_FDIS] ? sb_r[i] : filt_q[i];
      act[i]   = den_r[i] & ctl_r[i][svm_pkg::CTL_CMPE];
      resm[i]  = act[i] & ctl_r[i][svm_pkg::CTL_RIE] & ctl_r[i][svm_pkg::CTL_RI];
    end
    prev_nxt = lvl_f;
    rise     = act & lvl_f & ~prev_r;
    fall     = act & ~lvl_f & prev_r;
    for (int i = 0; i <= 2; i++)
    begin
      cnt_nxt[i] = (cnt_r[i] != '0) ? cnt_r[i] - 1'b1 : cnt_r[i];
      chrst[i]   = 1'b0;
      if (resm[i])
      begin
        if (i != 0 && ctl_r[i][svm_pkg::CTL_RN])
        begin
          // Timed reset started at the falling crossing
          if (fall[i])
            cnt_nxt[i] = svm_pkg::CNT_W'(svm_pkg::RESTART_CYC);
          chrst[i] = fall[i] | (cnt_r[i] != '0);
        end
        else
        begin
          // Held while below, released a fixed time after rising
          if (rise[i])
            cnt_nxt[i] = svm_pkg::CNT_W'(svm_pkg::RESTART_CYC);
          chrst[i] = ~lvl_f[i] | rise[i] | (cnt_r[i] != '0);
        end
      end
      else
        cnt_nxt[i] = '0;
    end
    rst_nxt = |chrst;
    for (int i = 1; i <= 2; i++)
      hit[i] = act[i] & ctl_r[i][svm_pkg::CTL_RIE] & ~ctl_r[i][svm_pkg::CTL_RI] &
               svm_pkg::tsel_hit(icfg_r[(i-1)*svm_pkg::IRQ_W +: 2], rise[i], fall[i]);
    irq_nxt = (hit[1] & ~icfg_r[2]) | (hit[2] & ~icfg_r[6]);
    nmi_nxt = (hit[1] & icfg_r[2]) | (hit[2] & icfg_r[6]);
    evt_nxt = {rise[2] | fall[2], rise[1] | fall[1]};
    // Register writes
    if (wr)
    begin
      unique case (PADDR_IN)
        svm_pkg::OFS_LEVEL:
        begin
          if (svm_pkg::lvl_valid(PWDATA_IN[3:0]))
            lvl_nxt[3:0] = PWDATA_IN[3:0];
          if (svm_pkg::lvl_valid(PWDATA_IN[7:4]))
            lvl_nxt[7:4] = PWDATA_IN[7:4];
        end
        svm_pkg::OFS_CTRL1:   ctl_nxt[1] = {1'b0, PWDATA_IN[6:0]};
        svm_pkg::OFS_CTRL2:   ctl_nxt[2] = {1'b0, PWDATA_IN[6:0]};
        svm_pkg::OFS_DETEN:   den_nxt = PWDATA_IN[2:0];
        svm_pkg::OFS_OPTION:
        begin
          if (PWDATA_IN[1])
            lvl0_nxt = PWDATA_IN[1:0];
        end
        svm_pkg::OFS_IRQCFG:  icfg_nxt = PWDATA_IN[7:0] & 8'h77;
        svm_pkg::OFS_STAT1:   det_nxt[1] = det_r[1] & PWDATA_IN[svm_pkg::ST_DET];
        svm_pkg::OFS_STAT2:   det_nxt[2] = det_r[2] & PWDATA_IN[svm_pkg::ST_DET];
        svm_pkg::OFS_INTSTAT: ist_nxt = ist_r & ~PWDATA_IN[2:0];
        svm_pkg::OFS_INTMASK: imsk_nxt = PWDATA_IN[2:0];
        default:              ;
      endcase
    end
    // Hardware sets win over software clears
    det_nxt = det_nxt | rise[2:1] | fall[2:1];
    hit_any = rst_nxt & ~rst_r;
    ist_nxt = ist_nxt | {hit_any, evt_nxt};
    int_nxt = |(ist_nxt & imsk_nxt);
    // Bus answer: one wait state
    rdy_nxt = PSEL_IN & PENABLE_IN & ~rdy_r;
    err_nxt = 1'b0;
    rd_nxt  = 32'h0000_0000;
    if (rd)
    begin
      unique case (PADDR_IN)
        svm_pkg::OFS_LEVEL:   rd_nxt = {24'h00_0000, lvl_r};
        svm_pkg::OFS_CTRL1:   rd_nxt = {24'h00_0000, ctl_r[1]};
        svm_pkg::OFS_CTRL2:   rd_nxt = {24'h00_0000, ctl_r[2]};
        svm_pkg::OFS_DETEN:   rd_nxt = {29'h0000_0000, den_r};
        svm_pkg::OFS_OPTION:  rd_nxt = {30'h0000_0000, lvl0_r};
        svm_pkg::OFS_IRQCFG:  rd_nxt = {24'h00_0000, icfg_r};
        svm_pkg::OFS_STAT1:   rd_nxt = {30'h0000_0000, prev_r[1], det_r[1]};
        svm_pkg::OFS_STAT2:   rd_nxt = {30'h0000_0000, prev_r[2], det_r[2]};
        svm_pkg::OFS_INTSTAT: rd_nxt = {29'h0000_0000, ist_r};
        svm_pkg::OFS_INTMASK: rd_nxt = {29'h0000_0000, imsk_r};
        default:              err_nxt = 1'b1;
      endcase
    end
    else if (PSEL_IN & PENABLE_IN & PWRITE_IN & ~rdy_r)
    begin
      unique case (PADDR_IN)
        svm_pkg::OFS_LEVEL, svm_pkg::OFS_CTRL1, svm_pkg::OFS_CTRL2, svm_pkg::OFS_DETEN,
        svm_pkg::OFS_OPTION, svm_pkg::OFS_IRQCFG, svm_pkg::OFS_STAT1, svm_pkg::OFS_STAT2,
        svm_pkg::OFS_INTSTAT, svm_pkg::OFS_INTMASK: err_nxt = 1'b0;
        default:                                     err_nxt = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      lvl_r  <= svm_pkg::RST_LEVEL;
      ctl_r  <= '{svm_pkg::RST_CTRL, svm_pkg::RST_CTRL};
      den_r  <= svm_pkg::RST_DETEN;
      lvl0_r <= svm_pkg::RST_LVL0;
      icfg_r <= svm_pkg::RST_IRQCFG;
      det_r  <= 2'h0;
      ist_r  <= 3'h0;
      imsk_r <= 3'h0;
      prev_r <= 3'h7;
      cnt_r  <= '{'0, '0, '0};
      rst_r  <= 1'b0;
      irq_r  <= 1'b0;
      nmi_r  <= 1'b0;
      evt_r  <= 2'h0;
      int_r  <= 1'b0;
      rdy_r  <= 1'b0;
      err_r  <= 1'b0;
      rd_r   <= 32'h0000_0000;
    end
    else
    begin
      lvl_r  <= lvl_nxt;
      ctl_r  <= ctl_nxt;
      den_r  <= den_nxt;
      lvl0_r <= lvl0_nxt;
      icfg_r <= icfg_nxt;
      det_r  <= det_nxt;
      ist_r  <= ist_nxt;
      imsk_r <= imsk_nxt;
      prev_r <= prev_nxt;
      cnt_r  <= cnt_nxt;
      rst_r  <= rst_nxt;
      irq_r  <= irq_nxt;
      nmi_r  <= nmi_nxt;
      evt_r  <= evt_nxt;
      int_r  <= int_nxt;
      rdy_r  <= rdy_nxt;
      err_r  <= err_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign PRDATA_OUT     = rd_r;
  assign PREADY_OUT     = rdy_r;
  assign PSLVERR_OUT    = err_r;
  assign LVL0_SEL_OUT   = lvl0_r;
  assign LVL1_SEL_OUT   = lvl_r[3:0];
  assign LVL2_SEL_OUT   = lvl_r[7:4];
  assign DET_ENABLE_OUT = den_r;
  assign MON_RESET_OUT  = rst_r;
  assign MON_IRQ_OUT    = irq_r;
  assign MON_NMI_OUT    = nmi_r;
  assign EVENT_OUT      = evt_r;
  assign INT_OUT        = int_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  property p_lvl1_legal;
    svm_pkg::lvl_valid(lvl_r[3:0]);
  endproperty
  a_lvl1_legal: assert property (p_lvl1_legal) else $error("illegal channel-1 level");

  property p_lvl2_legal;
    svm_pkg::lvl_valid(lvl_r[7:4]);
  endproperty
  a_lvl2_legal: assert property (p_lvl2_legal) else $error("illegal channel-2 level");

  property p_lvl0_legal;
    lvl0_r[1];
  endproperty
  a_lvl0_legal: assert property (p_lvl0_legal) else $error("reserved channel-0 level");

  property p_det_sticky;
    (rise[1] | fall[1]) |=> det_r[1] ##1 (det_r[1] || $past(wr && PADDR_IN == svm_pkg::OFS_STAT1));
  endproperty
  a_det_sticky: assert property (p_det_sticky) else $error("channel-1 crossing flag lost");

  property p_det2_set;
    (act[2] && lvl_f[2] != prev_r[2]) |=> det_r[2] && prev_r[2] == $past(lvl_f[2]);
  endproperty
  a_det2_set: assert property (p_det2_set) else $error("channel-2 crossing not flagged");

  sequence s_drop1;
    resm[1] && !ctl_r[1][svm_pkg::CTL_RN] && !lvl_f[1];
  endsequence
  property p_rst_below;
    s_drop1 |=> MON_RESET_OUT;
  endproperty
  a_rst_below: assert property (p_rst_below) else $error("reset not held while below");

  sequence s_rise0;
    resm[0] && rise[0];
  endsequence
  property p_ch0_restart;
    s_rise0 ##1 (resm[0] && lvl_f[0]) [*3] |-> MON_RESET_OUT;
  endproperty
  a_ch0_restart: assert property (p_ch0_restart) else $error("channel-0 released too early");

  property p_irq_mode;
    (hit[1] && !icfg_r[2] && !hit[2]) |=> MON_IRQ_OUT && !MON_NMI_OUT;
  endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("maskable interrupt missing");

  property p_int_mode_no_rst;
    (!resm[0] && !resm[1] && !resm[2] && cnt_r[1] == '0 && cnt_r[2] == '0 && cnt_r[0] == '0)
      |=> !MON_RESET_OUT;
  endproperty
  a_int_mode_no_rst: assert property (p_int_mode_no_rst) else $error("reset outside reset mode");

  property p_evt;
    EVENT_OUT[1] |-> $past(act[2]) && $past(lvl_f[2]) != $past(prev_r[2]);
  endproperty
  a_evt: assert property (p_evt) else $error("event without crossing");

  property p_filt_sel;
    (den_r[1] && !ctl_r[1][svm_pkg::CTL_FDIS]) |-> lvl_f[1] == filt_q[1];
  endproperty
  a_filt_sel: assert property (p_filt_sel) else $error("filter not used when enabled");

  property p_ready_pulse;
    PREADY_OUT |=> !PREADY_OUT;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

endmodule

// ===== logic/svm_pkg.sv
package svm_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LEVEL   = 8'h00;
  localparam logic [7:0] OFS_CTRL1   = 8'h04;
  localparam logic [7:0] OFS_CTRL2   = 8'h08;
  localparam logic [7:0] OFS_DETEN   = 8'h0C;
  localparam logic [7:0] OFS_OPTION  = 8'h10;
  localparam logic [7:0] OFS_IRQCFG  = 8'h14;
  localparam logic [7:0] OFS_STAT1   = 8'h18;
  localparam logic [7:0] OFS_STAT2   = 8'h1C;
  localparam logic [7:0] OFS_INTSTAT = 8'h20;
  localparam logic [7:0] OFS_INTMASK = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_RIE   = 0;
  localparam int CTL_FDIS  = 1;
  localparam int CTL_FSLO  = 2;
  localparam int CTL_RI    = 4;
  localparam int CTL_RN    = 5;
  localparam int CTL_CMPE  = 6;
  localparam int ST_DET    = 0;
  localparam int ST_MON    = 1;
  localparam int IRQ_W     = 4;
  localparam int INT_RST   = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LEVEL  = 8'h44;
  localparam logic [7:0] RST_CTRL   = 8'h02;
  localparam logic [2:0] RST_DETEN  = 3'h1;
  localparam logic [1:0] RST_LVL0   = 2'h2;
  localparam logic [7:0] RST_IRQCFG = 8'h00;

  // ----------------------------------------------------------------
  // Crossing timing select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TSEL_FALL = 2'h0;
  localparam logic [1:0] TSEL_RISE = 2'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int RESTART_TIME_NS = 1000;
  localparam int RESTART_CYC     = (RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 8;

  // Only five threshold codes are legal for channels 1 and 2
  function automatic logic lvl_valid(input logic [3:0] code);
    lvl_valid = (code == 4'h4) || (code == 4'h5) || (code == 4'h6) ||
                (code == 4'hA) || (code == 4'hB);
  endfunction

  // Crossing selected by timing code
  function automatic logic tsel_hit(input logic [1:0] tsel, input logic rise, input logic fall);
    if (tsel == TSEL_FALL)
      tsel_hit = fall;
    else if (tsel == TSEL_RISE)
      tsel_hit = rise;
    else
      tsel_hit = rise | fall;
  endfunction

endpackage

// ===== logic/svm_div.sv
`timescale 1ns/10ps
module svm_div
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Control
  input  wire logic       osc_edge_in,
  input  wire logic [1:0] sel_in,
  // Sample strobe
  output logic            sample_out
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       sample_r;
  logic       sample_nxt;
  logic [3:0] last;

  // Divide the oscillator edge stream by 2, 4, 8 or 16
  always_comb
  begin
    last       = 4'((5'h2 << sel_in) - 5'h1);
    cnt_nxt    = cnt_r;
    sample_nxt = 1'b0;
    if (osc_edge_in)
    begin
      if (cnt_r >= last)
      begin
        cnt_nxt    = 4'h0;
        sample_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_r    <= 4'h0;
      sample_r <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_nxt;
      sample_r <= sample_nxt;
    end
  end

  assign sample_out = sample_r;

  property p_div_rate;
    @(posedge clk_in) disable iff (rst_in)
      (osc_edge_in && sel_in == 2'h0 && cnt_r == 4'h1) |=> sample_r;
  endproperty
  a_div_rate: assert property (p_div_rate) else $error("divide-by-2 strobe missing");

endmodule

// ===== logic/svm_filt.sv
`timescale 1ns/10ps
module svm_filt
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Samples
  input  wire logic sample_in,
  input  wire logic d_in,
  // Filtered level
  output logic      q_out
);

  logic s_r;
  logic s_nxt;
  logic q_r;
  logic q_nxt;

  // Output follows only after two agreeing samples
  always_comb
  begin
    s_nxt = s_r;
    q_nxt = q_r;
    if (sample_in)
    begin
      s_nxt = d_in;
      if (d_in == s_r)
        q_nxt = d_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_r <= 1'b1;
      q_r <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_out = q_r;

  property p_filt_agree;
    @(posedge clk_in) disable iff (rst_in)
      (q_r != $past(q_r)) |-> ($past(sample_in) && $past(d_in) == $past(s_r));
  endproperty
  a_filt_agree: assert property (p_filt_agree) else $error("filter changed without two samples");

endmodule

// ===== verification/svm_cmp_model.sv
`timescale 1ns/10ps
module svm_cmp_model
(
  // Supply state and detector enables
  input  wire logic [2:0] supply_above_in,
  input  wire logic [2:0] det_enable_in,
  // Comparator levels and oscillator
  output logic [2:0]      cmp_above_out,
  output logic            osc_out
);
  // A disabled comparator shows a wrong level on purpose
  assign cmp_above_out = ~(supply_above_in ^ det_enable_in);

  // Free-running low-speed oscillator, 2.5 MHz
  initial
  begin
    osc_out = 1'b0;
    forever #200 osc_out = ~osc_out;
  end
endmodule

// ===== verification/svm_top_tb.sv
`timescale 1ns/10ps
module svm_top_tb;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  supply;
  logic [2:0]  cmp;
  logic [2:0]  deten;
  logic        osc;
  logic [1:0]  lvl0;
  logic [3:0]  lvl1;
  logic [3:0]  lvl2;
  logic        mrst;
  logic        mirq;
  logic        mnmi;
  logic        intr;
  logic [1:0]  ev;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          checks;
  int          n_irq;
  int          n_nmi;
  int          n_ev1;
  int          n_ev2;

  svm_top u_svm_top (.MCLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .CMP_ABOVE_IN(cmp), .LOW_SPEED_OSC_IN(osc), .LVL0_SEL_OUT(lvl0), .LVL1_SEL_OUT(lvl1),
    .LVL2_SEL_OUT(lvl2), .DET_ENABLE_OUT(deten), .MON_RESET_OUT(mrst), .MON_IRQ_OUT(mirq),
    .MON_NMI_OUT(mnmi), .EVENT_OUT(ev), .INT_OUT(intr));

  svm_cmp_model u_svm_cmp_model (.supply_above_in(supply), .det_enable_in(deten),
    .cmp_above_out(cmp), .osc_out(osc));

  // ----------------------------------------------------------------
  // Clock, pulse counters, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (mirq === 1'b1) n_irq++;
    if (mnmi === 1'b1) n_nmi++;
    if (ev[0] === 1'b1) n_ev1++;
    if (ev[1] === 1'b1) n_ev2++;
  end

  initial
  begin
    #400000;
    fails++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    chk("pready", n < 20, 1);
    rd   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rd, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [3:0] e;
    e = 4'h4;
    rdc("level", svm_pkg::OFS_LEVEL, 32'h0000_0044);
    rdc("ctrl1", svm_pkg::OFS_CTRL1, 32'h0000_0002);
    rdc("ctrl2", svm_pkg::OFS_CTRL2, 32'h0000_0002);
    rdc("deten", svm_pkg::OFS_DETEN, 32'h0000_0001);
    rdc("option", svm_pkg::OFS_OPTION, 32'h0000_0002);
    rdc("irqcfg", svm_pkg::OFS_IRQCFG, 32'h0000_0000);
    rdc("intmask", svm_pkg::OFS_INTMASK, 32'h0000_0000);
    for (int c = 0; c < 16; c++)
    begin
      if (c inside {4, 5, 6, 10, 11}) e = c[3:0];
      apb(1'b1, svm_pkg::OFS_LEVEL, {24'h0, c[3:0], c[3:0]});
      cyc(2);
      chk("lvl1", {28'h0, lvl1}, {28'h0, e});
      chk("lvl2", {28'h0, lvl2}, {28'h0, e});
    end
    apb(1'b1, svm_pkg::OFS_LEVEL, 32'h0000_0044);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, svm_pkg::OFS_OPTION, {30'h0, 2'(c ^ 1)});
      cyc(2);
      chk("lvl0", {30'h0, lvl0}, (c == 2) ? 32'h0000_0003 : 32'h0000_0002);
    end
    apb(1'b1, svm_pkg::OFS_OPTION, 32'h0000_0002);
    rdc("unmapped", 8'h40, 32'h0000_0000);
    chk("slverr", {31'h0, err}, 1);
  endtask

  task automatic t_ch0();
    @(posedge clk);
    supply[0] <= 1'b0;
    cyc(10);
    chk("rst0", {31'h0, mrst}, 1);
    rdc("intstat", svm_pkg::OFS_INTSTAT, 32'h0000_0004);
    chk("int_masked", {31'h0, intr}, 0);
    supply[0] <= 1'b1;
    cyc(10);
    chk("rst0_hold", {31'h0, mrst}, 1);
    cyc(30);
    chk("rst0_free", {31'h0, mrst}, 0);
    apb(1'b1, svm_pkg::OFS_INTMASK, 32'h0000_0004);
    cyc(2);
    chk("int_on", {31'h0, intr}, 1);
    apb(1'b1, svm_pkg::OFS_INTSTAT, 32'h0000_0004);
    cyc(2);
    chk("int_clr", {31'h0, intr}, 0);
  endtask

  task automatic t_ch1();
    apb(1'b1, svm_pkg::OFS_DETEN, 32'h0000_0007);
    cyc(20);
    apb(1'b1, svm_pkg::OFS_CTRL1, 32'h0000_0002);
    apb(1'b1, svm_pkg::OFS_STAT1, 32'h0000_0000);
    apb(1'b1, svm_pkg::OFS_CTRL1, 32'h0000_0003);
    apb(1'b1, svm_pkg::OFS_CTRL1, 32'h0000_0043);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, svm_pkg::OFS_IRQCFG, (i < 2) ? 32'h0000_0000 + 5 * i : 32'h0000_0002);
      supply[1] <= i[0];
      cyc(10);
      chk("irq", n_irq, (i == 0) ? 1 : i);
      chk("nmi", n_nmi, (i == 0) ? 0 : 1);
      chk("ev1", n_ev1, i + 1);
      chk("rst1", {31'h0, mrst}, 0);
      rdc("stat1", svm_pkg::OFS_STAT1, {30'h0, i[0], 1'b1});
    end
    apb(1'b1, svm_pkg::OFS_CTRL1, 32'h0000_0003);
    apb(1'b1, svm_pkg::OFS_CTRL1, 32'h0000_0002);
    supply[1] <= 1'b0;
    cyc(10);
    chk("ev1_off", n_ev1, 4);
  endtask

  task automatic t_ch2();
    int n;
    apb(1'b1, svm_pkg::OFS_CTRL2, 32'h0000_0006);
    apb(1'b1, svm_pkg::OFS_CTRL2, 32'h0000_0004);
    cyc(100);
    apb(1'b1, svm_pkg::OFS_CTRL2, 32'h0000_0014);
    apb(1'b1, svm_pkg::OFS_STAT2, 32'h0000_0000);
    apb(1'b1, svm_pkg::OFS_CTRL2, 32'h0000_0015);
    apb(1'b1, svm_pkg::OFS_CTRL2, 32'h0000_0055);
    supply[2] <= 1'b0;
    @(posedge clk);
    supply[2] <= 1'b1;
    cyc(150);
    chk("glitch", n_ev2, 0);
    supply[2] <= 1'b0;
    cyc(28);
    chk("filt_slow", {31'h0, mrst}, 0);
    cyc(100);
    chk("rst2", {31'h0, mrst}, 1);
    chk("ev2", n_ev2, 1);
    rdc("stat2", svm_pkg::OFS_STAT2, 32'h0000_0001);
    supply[2] <= 1'b1;
    cyc(150);
    chk("rst2_free", {31'h0, mrst}, 0);
    apb(1'b1, svm_pkg::OFS_CTRL2, 32'h0000_0075);
    supply[2] <= 1'b0;
    n = 0;
    while (mrst !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge clk);
    end
    n = 0;
    while (mrst === 1'b1 && n < 100)
    begin
      n++;
      @(posedge clk);
    end
    chk("pulse", n, 21);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst    = 1'b1;
    psel   = 1'b0;
    pen    = 1'b0;
    pwr    = 1'b0;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    supply = 3'h7;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_ch0();
    t_ch1();
    t_ch2();
    close_out();
  end
endmodule
